// *** logic/qls_pkg.sv ***
package qls_pkg;
  localparam int unsigned WORD_W = 12;
  localparam int unsigned NUM_CH = 4;
  localparam logic [3:0] LAST_SLOT = 4'hb;
  localparam logic [3:0] HALF_SLOT = 4'h6;
  localparam int unsigned PIPE_DEPTH = 7;
  // Timing figures as printed, and cycle counts at the 12x clock clk_i
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned STOP_FREQ_KHZ = 3000;
  localparam int unsigned MIN_RATE_KHZ = 20000;
  localparam logic [7:0] STOP_CYC = 8'((CLK_MHZ * 1000) / STOP_FREQ_KHZ);
  localparam logic [7:0] LOW_RATE_CYC = 8'((CLK_MHZ * 1000) / MIN_RATE_KHZ);
  // Wishbone byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CUSTOM_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  // Control fields
  localparam int unsigned CTRL_MSB_FIRST = 0;
  localparam int unsigned CTRL_DESKEW = 1;
  localparam int unsigned CTRL_SYNC = 2;
  localparam int unsigned CTRL_CUSTOM = 3;
  localparam int unsigned CTRL_MON_DIS = 4;
  localparam int unsigned CTRL_CH_PD_LSB = 8;
  localparam int unsigned CTRL_DRIVE_LSB = 12;
  localparam logic [13:0] CTRL_RESET = 14'h0000;
  localparam logic [11:0] CUSTOM_RESET = 12'h000;
  // Status fields
  localparam int unsigned STAT_PD = 0;
  localparam int unsigned STAT_STOPPED = 1;
  localparam int unsigned STAT_RATE_LOW = 2;
  localparam int unsigned STAT_PIN = 3;
  localparam int unsigned STAT_MODE_LSB = 4;
  // Patterns in time order, bit 0 sent first
  localparam logic [11:0] DESKEW_WORD = 12'haaa;
  localparam logic [11:0] SYNC_WORD = 12'hfc0;
  typedef enum logic [1:0]
  {
    QLS_DATA = 2'b00,
    QLS_CUSTOM = 2'b01,
    QLS_SYNC = 2'b10,
    QLS_DESKEW = 2'b11
  } qls_mode_t;
endpackage

// *** logic/qls_serializer.sv ***
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ns
// Summary of operation
// RULE1 - One shared strobe captures all four channels
// RULE2 - Sample clock must exceed about 20MSPS
// RULE3 - Each 12-bit word fills one frame
// RULE4 - LSB first by default, MSB optional
// RULE5 - Bit clock at six times sample rate
// RULE6 - Deskew mode sends alternating zeros and ones
// RULE7 - Receiver may deskew using alternating pattern
// RULE8 - Frame clock rises at word start
// RULE9 - Sync mode sends six zeros, six ones
// RULE10 - Receiver aligns words to frame clock
// RULE11 - User custom pattern replaces samples
// RULE12 - Four drive settings, 3.5mA after reset
// RULE13 - Power-down pin stops reference, clock, channels
// RULE14 - Per-channel power-down via register bits
// RULE15 - Stopped or sub-3MHz clock forces power-down
// RULE16 - Register bit disables stopped-clock monitor
// RULE17 - Controller pulses reset after supplies settle
// RULE18 - Reset clears all configuration to zero
// RULE19 - Sample latency is 6.5 sample cycles
// RULE20 - Bit and frame clocks divided from 12x
// RULE21 - Mode changes only at frame boundaries
module qls_serializer
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sample_clock_in_i,
  input wire logic power_down_pin_i,
  input wire logic [qls_pkg::WORD_W-1:0] sample_ch0_i,
  input wire logic [qls_pkg::WORD_W-1:0] sample_ch1_i,
  input wire logic [qls_pkg::WORD_W-1:0] sample_ch2_i,
  input wire logic [qls_pkg::WORD_W-1:0] sample_ch3_i,
  output logic lane0_o,
  output logic lane1_o,
  output logic lane2_o,
  output logic lane3_o,
  output logic bit_clock_out_pair_p_o,
  output logic bit_clock_out_pair_n_o,
  output logic frame_clock_out_pair_p_o,
  output logic frame_clock_out_pair_n_o,
  output logic sample_strobe_o,
  output logic [1:0] drive_sel_o,
  output logic ref_pd_o,
  output logic clk_pd_o,
  output logic [qls_pkg::NUM_CH-1:0] ch_pd_o
);
  import qls_pkg::*;

  function automatic logic pick_bit(input logic [WORD_W-1:0] word, input logic [3:0] idx,
                                    input logic rev);
    logic [3:0] pos;
    pos = rev ? 4'(LAST_SLOT - idx) : idx;
    return word[pos];
  endfunction

  logic [13:0] ctrl_ff;
  logic [11:0] custom_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic pd_s1_ff, pd_s2_ff;
  logic [7:0] period_ff;
  logic stopped_ff;
  logic rate_low_ff;
  logic [3:0] slot_ff;
  logic [3:0] nxt_slot;
  qls_mode_t mode_ff;
  qls_mode_t nxt_mode;
  logic msb_first_ff;
  logic [WORD_W-1:0] pipe_ff [PIPE_DEPTH][NUM_CH];
  logic [WORD_W-1:0] word_ff [NUM_CH];
  logic [WORD_W-1:0] nxt_word [NUM_CH];
  logic [NUM_CH-1:0] lane_ff;
  logic bclk_ff, fclk_ff, strobe_ff;
  logic bclk_n_ff, fclk_n_ff;
  logic [1:0] drive_ff;
  logic ref_pd_ff, clk_pd_ff;
  logic [NUM_CH-1:0] ch_pd_ff;
  logic global_pd;
  logic bus_req;
  logic sclk_rise;
  logic [WORD_W-1:0] samples [NUM_CH];

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign sclk_rise = sclk_s2_ff && !sclk_s3_ff;
  assign samples[0] = sample_ch0_i;
  assign samples[1] = sample_ch1_i;
  assign samples[2] = sample_ch2_i;
  assign samples[3] = sample_ch3_i;
  // Monitor can be overruled so that a gated clock does not drop the part
  assign global_pd = pd_s2_ff || (stopped_ff && !ctrl_ff[CTRL_MON_DIS]);  // see RULE13 RULE16

  // Wishbone slave: one wait state, write lands on the ack edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= bus_req;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff <= CTRL_RESET;  // see RULE18
      custom_ff <= CUSTOM_RESET;
    end
    else if (bus_req && wb_we_i)
    begin
      if (wb_adr_i == CTRL_OFS)
      begin
        if (wb_sel_i[0])
        begin
          ctrl_ff[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
          ctrl_ff[13:8] <= wb_dat_i[13:8];
        end
      end
      else if (wb_adr_i == CUSTOM_OFS)
      begin
        if (wb_sel_i[0])
        begin
          custom_ff[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
          custom_ff[11:8] <= wb_dat_i[11:8];
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdat_ff <= 32'h0000_0000;
    end
    else if (bus_req && !wb_we_i)
    begin
      rdat_ff <= 32'h0000_0000;
      case (wb_adr_i)
        CTRL_OFS: rdat_ff[13:0] <= ctrl_ff;
        CUSTOM_OFS: rdat_ff[11:0] <= custom_ff;
        STATUS_OFS:
        begin
          rdat_ff[STAT_PD] <= global_pd;
          rdat_ff[STAT_STOPPED] <= stopped_ff;
          rdat_ff[STAT_RATE_LOW] <= rate_low_ff;
          rdat_ff[STAT_PIN] <= pd_s2_ff;
          rdat_ff[STAT_MODE_LSB +: 2] <= mode_ff;
        end
        default: rdat_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      pd_s1_ff <= 1'b0;
      pd_s2_ff <= 1'b0;
    end
    else
    begin
      sclk_s1_ff <= sample_clock_in_i;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      pd_s1_ff <= power_down_pin_i;
      pd_s2_ff <= pd_s1_ff;
    end
  end

  // Sample clock period monitor; the counter saturates so it never wraps
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      period_ff <= 8'h00;
      stopped_ff <= 1'b0;
      rate_low_ff <= 1'b0;
    end
    else if (sclk_rise)
    begin
      period_ff <= 8'h00;
      stopped_ff <= 1'b0;
      rate_low_ff <= (period_ff > LOW_RATE_CYC);  // see RULE2
    end
    else if (period_ff >= STOP_CYC)
    begin
      stopped_ff <= 1'b1;  // see RULE15
      rate_low_ff <= 1'b1;
    end
    else
    begin
      period_ff <= period_ff + 8'h01;
    end
  end

  // Frame slot counter at the 12x rate
  assign nxt_slot = (slot_ff == LAST_SLOT) ? 4'h0 : 4'(slot_ff + 4'h1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || global_pd)
    begin
      slot_ff <= LAST_SLOT;
    end
    else
    begin
      slot_ff <= nxt_slot;  // see RULE3 RULE20
    end
  end

  always_comb
  begin
    nxt_mode = QLS_DATA;
    if (ctrl_ff[CTRL_DESKEW])
    begin
      nxt_mode = QLS_DESKEW;
    end
    else if (ctrl_ff[CTRL_SYNC])
    begin
      nxt_mode = QLS_SYNC;
    end
    else if (ctrl_ff[CTRL_CUSTOM])
    begin
      nxt_mode = QLS_CUSTOM;
    end
  end

  // Mode and order are taken only as a new word starts
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_ff <= QLS_DATA;
      msb_first_ff <= 1'b0;
    end
    else if (nxt_slot == 4'h0)
    begin
      mode_ff <= nxt_mode;  // see RULE21
      msb_first_ff <= ctrl_ff[CTRL_MSB_FIRST];
    end
  end

  // One shared mid-frame strobe captures every channel at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strobe_ff <= 1'b0;
    end
    else
    begin
      strobe_ff <= !global_pd && (nxt_slot == HALF_SLOT);  // see RULE1
    end
  end

  // Seven words deep: capture at mid-frame plus six frames gives 6.5
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int d = 0; d < PIPE_DEPTH; d++)
      begin
        for (int c = 0; c < NUM_CH; c++)
        begin
          pipe_ff[d][c] <= '0;
        end
      end
    end
    else if (!global_pd && nxt_slot == HALF_SLOT)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        pipe_ff[0][c] <= samples[c];  // see RULE19
        for (int d = 1; d < PIPE_DEPTH; d++)
        begin
          pipe_ff[d][c] <= pipe_ff[d-1][c];
        end
      end
    end
  end

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      case (nxt_mode)
        QLS_DESKEW: nxt_word[c] = DESKEW_WORD;  // see RULE6
        QLS_SYNC: nxt_word[c] = SYNC_WORD;  // see RULE9
        QLS_CUSTOM: nxt_word[c] = custom_ff;  // see RULE11
        default: nxt_word[c] = pipe_ff[PIPE_DEPTH-1][c];
      endcase
    end
  end

  // Patterns are time ordered and skip the bit reversal; only samples obey it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lane_ff <= '0;
      for (int c = 0; c < NUM_CH; c++)
      begin
        word_ff[c] <= '0;
      end
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (global_pd || ctrl_ff[CTRL_CH_PD_LSB + c])
        begin
          lane_ff[c] <= 1'b0;  // see RULE13 RULE14
        end
        else if (nxt_slot == 4'h0)
        begin
          word_ff[c] <= nxt_word[c];
          lane_ff[c] <= pick_bit(nxt_word[c], 4'h0,
                                 ctrl_ff[CTRL_MSB_FIRST] && nxt_mode == QLS_DATA);  // see RULE4
        end
        else
        begin
          lane_ff[c] <= pick_bit(word_ff[c], nxt_slot, msb_first_ff && mode_ff == QLS_DATA);
        end
      end
    end
  end

  // Clocks derived from the same slot count stay locked to the data
  always_ff @(posedge clk_i)
  begin
    if (rst_i || global_pd)
    begin
      bclk_ff <= 1'b0;
      fclk_ff <= 1'b0;
      bclk_n_ff <= 1'b1;
      fclk_n_ff <= 1'b1;
    end
    else
    begin
      bclk_ff <= !nxt_slot[0];  // see RULE5 RULE20
      fclk_ff <= (nxt_slot < HALF_SLOT);  // see RULE8
      // Own flops for the inverted legs keep every pin registered
      bclk_n_ff <= nxt_slot[0];
      fclk_n_ff <= (nxt_slot >= HALF_SLOT);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      drive_ff <= 2'b00;
      ref_pd_ff <= 1'b0;
      clk_pd_ff <= 1'b0;
      ch_pd_ff <= '0;
    end
    else
    begin
      drive_ff <= ctrl_ff[CTRL_DRIVE_LSB +: 2];  // see RULE12
      ref_pd_ff <= global_pd;  // see RULE13
      clk_pd_ff <= global_pd;
      ch_pd_ff <= {NUM_CH{global_pd}} | ctrl_ff[CTRL_CH_PD_LSB +: NUM_CH];  // see RULE14
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign lane0_o = lane_ff[0];
  assign lane1_o = lane_ff[1];
  assign lane2_o = lane_ff[2];
  assign lane3_o = lane_ff[3];
  assign bit_clock_out_pair_p_o = bclk_ff;
  assign bit_clock_out_pair_n_o = bclk_n_ff;
  assign frame_clock_out_pair_p_o = fclk_ff;
  assign frame_clock_out_pair_n_o = fclk_n_ff;
  assign sample_strobe_o = strobe_ff;
  assign drive_sel_o = drive_ff;
  assign ref_pd_o = ref_pd_ff;
  assign clk_pd_o = clk_pd_ff;
  assign ch_pd_o = ch_pd_ff;
endmodule // qls_serializer

// *** sim/qls_props.sv ***
`timescale 1ns/1ns
module qls_props
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic power_down_pin_i,
  input wire logic lane0_o,
  input wire logic bit_clock_out_pair_p_o,
  input wire logic bit_clock_out_pair_n_o,
  input wire logic frame_clock_out_pair_p_o,
  input wire logic sample_strobe_o,
  input wire logic ref_pd_o,
  input wire logic clk_pd_o,
  input wire logic [qls_pkg::NUM_CH-1:0] ch_pd_o
);
  import qls_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held too long");
  // A power-down cuts a frame short, so framing checks pause meanwhile
  property p_frame;
    disable iff (rst_i || clk_pd_o)
    $rose(frame_clock_out_pair_p_o) |->
      frame_clock_out_pair_p_o [*6] ##1 !frame_clock_out_pair_p_o [*6];
  endproperty
  a_frame: assert property (p_frame) else $error("frame shape wrong");
  property p_strobe;
    sample_strobe_o |-> !frame_clock_out_pair_p_o && $past(frame_clock_out_pair_p_o);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe off slot");
  property p_bitclk;
    disable iff (rst_i || clk_pd_o)
    $rose(frame_clock_out_pair_p_o) |->
      bit_clock_out_pair_p_o ##1 !bit_clock_out_pair_p_o ##1 bit_clock_out_pair_p_o;
  endproperty
  a_bitclk: assert property (p_bitclk) else $error("bit clock phase");
  property p_comp;
    bit_clock_out_pair_p_o != bit_clock_out_pair_n_o;
  endproperty
  a_comp: assert property (p_comp) else $error("bit clock pair");
  property p_pd_all;
    clk_pd_o |-> ref_pd_o && ch_pd_o == 4'hf;
  endproperty
  a_pd_all: assert property (p_pd_all) else $error("partial power down");
  property p_pin;
    $rose(power_down_pin_i) |-> ##[1:5] clk_pd_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pin ignored");
  property p_chpd;
    ch_pd_o[0] [*2] |-> !lane0_o;
  endproperty
  a_chpd: assert property (p_chpd) else $error("lane not quiet");
endmodule // qls_props
bind qls_serializer qls_props i_props (.clk_i, .rst_i, .wb_ack_o, .power_down_pin_i,
  .lane0_o, .bit_clock_out_pair_p_o, .bit_clock_out_pair_n_o, .frame_clock_out_pair_p_o,
  .sample_strobe_o, .ref_pd_o, .clk_pd_o, .ch_pd_o);

// *** sim/qls_rx_model.sv ***
`timescale 1ns/1ns
module qls_rx_model
(
  input wire logic clk_i,
  input wire logic lane_i,
  input wire logic bit_p_i,
  input wire logic frame_p_i,
  output logic [11:0] word_o
);
  logic [11:0] sh_ff;
  logic [3:0] cnt_ff = 4'h0;
  logic fp_ff = 1'b0;
  logic bp_ff = 1'b0;
  always_ff @(posedge clk_i)
  begin
    bp_ff <= bit_p_i;
    // Both edges of the bit clock carry a bit, so any change captures
    // Capture point sits at the clock change; the alternating pattern proves it
    if (bit_p_i != bp_ff)
    begin
      fp_ff <= frame_p_i;
      sh_ff <= {lane_i, sh_ff[11:1]};
      if (frame_p_i && !fp_ff)
        cnt_ff <= 4'h1;
      else if (cnt_ff != 4'h0 && cnt_ff != 4'hc)
        cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == 4'hc)
        word_o <= sh_ff;
    end
  end
endmodule // qls_rx_model

// *** sim/qls_serializer_tb_top.sv ***
`timescale 1ns/1ns
module qls_serializer_tb_top;
  import qls_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sample_clock_in_i = 1'b0;
  logic power_down_pin_i = 1'b0;
  logic [11:0] smp = 12'h3c5;
  logic lane0_o, lane1_o, lane2_o, lane3_o;
  logic bit_clock_out_pair_p_o, bit_clock_out_pair_n_o, frame_clock_out_pair_p_o;
  logic frame_clock_out_pair_n_o, sample_strobe_o, ref_pd_o, clk_pd_o;
  logic [1:0] drive_sel_o;
  logic [3:0] ch_pd_o;
  logic [11:0] rx_word;
  logic [11:0] rx_w [1:3];
  logic [11:0] prev_w;
  logic [3:0] lanes;
  logic sck_run = 1'b1;
  logic [2:0] sdiv = 3'h0;
  logic [31:0] q;
  logic [11:0] mode_exp [3] = '{12'haaa, 12'hfc0, 12'h5a3};
  int error_cnt = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  always #2 clk_i = ~clk_i;
  qls_serializer i_dut
  (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .sample_clock_in_i, .power_down_pin_i, .sample_ch0_i(smp),
    .sample_ch1_i(smp ^ 12'h111), .sample_ch2_i(smp ^ 12'h222), .sample_ch3_i(smp ^ 12'h444),
    .lane0_o, .lane1_o,
    .lane2_o, .lane3_o, .bit_clock_out_pair_p_o, .bit_clock_out_pair_n_o,
    .frame_clock_out_pair_p_o, .frame_clock_out_pair_n_o, .sample_strobe_o,
    .drive_sel_o, .ref_pd_o, .clk_pd_o, .ch_pd_o
  );
  qls_rx_model i_rx
  (
    .clk_i, .lane_i(lane0_o), .bit_p_i(bit_clock_out_pair_p_o),
    .frame_p_i(frame_clock_out_pair_p_o), .word_o(rx_word)
  );
  assign lanes = {lane3_o, lane2_o, lane1_o, lane0_o};
  // One receiver per further lane, so every channel is seen at the far side
  for (genvar g = 1; g < 4; g++)
  begin : g_rx
    qls_rx_model i_rx
    (
      .clk_i, .lane_i(lanes[g]), .bit_p_i(bit_clock_out_pair_p_o),
      .frame_p_i(frame_clock_out_pair_p_o), .word_o(rx_w[g])
    );
  end
  // Sample clock period of 12 cycles stays inside the low-rate limit, so the low-rate flag stays clear
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (sck_run)
      sdiv <= (sdiv == 3'h5) ? 3'h0 : sdiv + 3'h1;
    if (sck_run && sdiv == 3'h5)
      sample_clock_in_i <= ~sample_clock_in_i;
    if (cyc_cnt == 6000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic do_rst();
    rst_i <= 1'b1;
    tick(12);
    rst_i <= 1'b0;
    tick(1);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    do_rst();
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(q, 32'h0);
    chk(drive_sel_o, 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    // Long wait lets the constant sample flush through the pipe
    tick(120);
    chk(rx_word, 12'h3c5);
    chk(rx_w[1], 12'h2d4);
    chk(rx_w[2], 12'h1e7);
    chk(rx_w[3], 12'h781);
    // New samples set just after a capture wait a frame to be captured, then 6.5 frames, plus one frame to receive
    @(posedge clk_i iff sample_strobe_o);
    smp <= 12'h0f6;
    tick(96);
    chk(rx_word, 12'h3c5);
    chk(rx_w[3], 12'h781);
    tick(12);
    chk(rx_word, 12'h0f6);
    chk(rx_w[3], 12'h4b2);
    wb(1'b1, CTRL_OFS, 32'h1);
    tick(40);
    chk(rx_word, 12'h6f0);
    wb(1'b1, CUSTOM_OFS, 32'h5a3);
    prev_w = 12'h6f0;
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, CTRL_OFS, 32'h1 << (i + 1));
      // Every word seen across the switch is whole: old or new, never a blend
      repeat (40)
      begin
        @(posedge clk_i);
        if (rx_word !== prev_w && rx_word !== mode_exp[i])
          chk(rx_word, mode_exp[i]);
      end
      chk(rx_word, mode_exp[i]);
      prev_w = mode_exp[i];
      wb(1'b0, STATUS_OFS, 32'h0);
      chk(q[5:0], 32'((3 - i) << 4));
    end
    wb(1'b1, CTRL_OFS, 32'h3100);
    tick(40);
    chk(rx_word, 12'h000);
    chk(rx_w[1], 12'h1e7);
    chk(ch_pd_o, 4'h1);
    chk(drive_sel_o, 2'h3);
    power_down_pin_i <= 1'b1;
    tick(10);
    chk({ref_pd_o, clk_pd_o, ch_pd_o}, 6'h3f);
    power_down_pin_i <= 1'b0;
    sck_run <= 1'b0;
    tick(100);
    chk(clk_pd_o, 1'b1);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(q, 32'h7);
    wb(1'b1, CTRL_OFS, 32'h10);
    tick(10);
    chk(clk_pd_o, 1'b0);
    sck_run <= 1'b1;
    do_rst();
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(q, 32'h0);
    end_of_test();
  end
endmodule // qls_serializer_tb_top
